// File: rtl/rx_payload_pkg.sv
// Package for the receive payload output port: register map, field layouts,
// reset values, frame geometry and timing constants.
// Assumes an 8-bit register port and a 250 MHz system clock.
`default_nettype none
package rx_payload_pkg;

  // Register offsets
  localparam logic [7:0] PRIMARY_CONTROL_OFS = 8'h01;
  localparam logic [7:0] OUTPUT_CONTROL_OFS  = 8'h04;
  localparam logic [7:0] FRAMER_STATUS_OFS   = 8'h10;
  localparam logic [7:0] ERR_COUNT_LO_OFS    = 8'h20;
  localparam logic [7:0] ERR_COUNT_HI_OFS    = 8'h21;

  // Output control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] spare;
    logic       e3Mode;
    logic       diagLoopback;
    logic       outputClockInvert;
    logic       framePulseInvert;
    logic       markerPolarityInvert;
    logic       markerModeSelect;
  } output_ctrl_t;

  // Primary control register layout
  typedef struct packed {
    logic [2:0] spare;
    logic       manualCounterUpdate;
    logic       autoCounterUpdateEn;
    logic [2:0] spareLow;
  } primary_ctrl_t;

  // Framer status register layout
  typedef struct packed {
    logic [5:0] spare;
    logic       outOfFrame;
    logic       signalLoss;
  } framer_status_t;

  localparam output_ctrl_t  OUTPUT_CTRL_RST  = 8'h00;
  localparam primary_ctrl_t PRIMARY_CTRL_RST = 8'h00;

  // Frame geometry
  localparam logic [12:0] DS3_LAST_POS   = 13'h1297; // 4760 bits per multiframe
  localparam logic [6:0]  DS3_BLOCK_LAST = 7'h54;    // 85 bits per block
  localparam logic [12:0] E3_LAST_POS    = 13'h05ff; // 1536 bits per frame
  localparam logic [12:0] E3_OVH_BITS    = 13'h000c; // Bits 1 to 12

  // Counter load deadline
  localparam int CLOCK_PERIOD_PS   = 4000;
  localparam int LOAD_DEADLINE_NS  = 100;
  localparam int LOAD_DEADLINE_CYC = (LOAD_DEADLINE_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int LOAD_LATENCY_CYC  = 4;

endpackage
`default_nettype wire

// File: rtl/receive_payload_output_port.sv
// Receive payload output stage of one framer: serial data, payload marker,
// frame boundary pulse, alarm outputs, counter update strobe.
// Assumes framer core signals share the system clock; link clocks and the
// external update strobe are asynchronous pins.
//
// Overview of operation
// - Marker pin is a data enable when mode bit is 0, gapped clock when 1.
// - Data enable is active during payload bits, inactive during overhead bits.
// - Gapped clock toggles on payload bit positions, stays still on overhead.
// - DS3 overhead is the first bit of every 85-bit block, all else payload.
// - E3 overhead is frame bits 1 to 12.
// - Polarity bit inverts the data enable, or the gapped clock.
// - Frame pulse lasts one link clock cycle on the last frame bit.
// - Frame pulse is active high, active low when its invert bit is 1.
// - Loss output is high exactly while the framer is in loss of signal.
// - Out-of-frame output is high exactly while the framer is out of frame.
// - Loss and out-of-frame states are readable in the status register.
// - External update works only when auto-update is enabled; it reaches all framers.
// - Rising edge of the update request copies live error counts to readable registers.
// - Counter registers are loaded well within 100 ns of the update edge.
// - Update request is the OR of the external strobe and the manual bit.
// - Output clock follows the line clock, or the transmit clock in loopback.
// - Data launches on output clock rise, or fall when output clock is inverted.
//
// Our own choices: the register addresses and the plain strobed port.
`default_nettype none
module receive_payload_output_port
  import rx_payload_pkg::*;
(
  // Clock and reset
  input  wire  logic        clock,
  input  wire  logic        arst_n,
  // Link clock pins
  input  wire  logic        rxLineClock,
  input  wire  logic        txInputClock,
  // Framer core, system clock domain
  input  wire  logic        coreBitData,
  input  wire  logic        coreFrameStart,
  input  wire  logic        coreSignalLoss,
  input  wire  logic        coreOutOfFrame,
  input  wire  logic [15:0] coreErrCount,
  // Counter update strobe pin and fan-out
  input  wire  logic        extCounterUpdateIn,
  output logic              counterUpdatePulse,
  // Serial output side
  output logic              rxOutputClock,
  output logic              rxSerialDataOut,
  output logic              rxPayloadEnable,
  output logic              rxFramePulse,
  output logic              rxSignalLossOut,
  output logic              rxOutOfFrameOut,
  // Register port
  input  wire  logic [7:0]  regAddr,
  input  wire  logic [7:0]  regWdata,
  input  wire  logic        regWrite,
  input  wire  logic        regRead,
  output logic [7:0]        regRdata
);

  // Overhead classification of a bit position
  function automatic logic isOverhead(input logic e3, input logic [12:0] pos, input logic [6:0] blk);
    isOverhead = e3 ? (pos < E3_OVH_BITS) : (blk == 7'h00);
  endfunction

  // Last bit of a frame
  function automatic logic isLastBit(input logic e3, input logic [12:0] pos);
    isLastBit = e3 ? (pos == E3_LAST_POS) : (pos == DS3_LAST_POS);
  endfunction

  output_ctrl_t   outCtrl_r;
  output_ctrl_t   outCtrl_nxt;
  primary_ctrl_t  priCtrl_r;
  primary_ctrl_t  priCtrl_nxt;
  framer_status_t status;
  logic [15:0]    errHeld_r;
  logic [15:0]    errHeld_nxt;
  logic [7:0]     rdata_r;
  logic [7:0]     rdata_nxt;

  logic [1:0]     lineSync_r;
  logic [1:0]     txSync_r;
  logic [2:0]     updSync_r;
  logic           selClk;
  logic           selPrev_r;
  logic           tick;

  logic [12:0]    pos_r;
  logic [12:0]    pos_nxt;
  logic [6:0]     blk_r;
  logic [6:0]     blk_nxt;
  logic           payload_r;
  logic           payload_nxt;
  logic           last_r;
  logic           last_nxt;
  logic           data_r;
  logic           data_nxt;
  logic           outClk_r;
  logic           outClk_nxt;
  logic           marker_r;
  logic           marker_nxt;
  logic           frame_r;
  logic           frame_nxt;
  logic           los_r;
  logic           oof_r;
  logic           updReq;
  logic           updPrev_r;
  logic           updEdge;
  logic           updPulse_r;

  // Two-flop synchronisers plus one edge stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lineSync_r <= 2'h0;
      txSync_r   <= 2'h0;
      updSync_r  <= 3'h0;
    end else begin
      lineSync_r <= {lineSync_r[0], rxLineClock};
      txSync_r   <= {txSync_r[0], txInputClock};
      updSync_r  <= {updSync_r[1:0], extCounterUpdateIn};
    end
  end

  // Source clock choice and its rising edge
  assign selClk = outCtrl_r.diagLoopback ? txSync_r[1] : lineSync_r[1];
  assign tick   = selClk & ~selPrev_r;

  // Bit position tracking and output next values
  always_comb begin
    pos_nxt     = pos_r;
    blk_nxt     = blk_r;
    payload_nxt = payload_r;
    last_nxt    = last_r;
    data_nxt    = data_r;
    if (tick) begin
      if (coreFrameStart || isLastBit(outCtrl_r.e3Mode, pos_r)) begin
        pos_nxt = 13'h0000;
        blk_nxt = 7'h00;
      end else begin
        pos_nxt = pos_r + 13'h0001;
        blk_nxt = (blk_r == DS3_BLOCK_LAST) ? 7'h00 : blk_r + 7'h01;
      end
      payload_nxt = ~isOverhead(outCtrl_r.e3Mode, pos_nxt, blk_nxt);
      last_nxt    = isLastBit(outCtrl_r.e3Mode, pos_nxt);
      data_nxt    = coreBitData;
    end
    // Output clock copies the source, inverted on request
    outClk_nxt = selClk ^ outCtrl_r.outputClockInvert;
    // Marker: enable level or gapped clock
    if (outCtrl_r.markerModeSelect) begin
      marker_nxt = (selClk & payload_nxt) ^ outCtrl_r.markerPolarityInvert;
    end else begin
      marker_nxt = payload_nxt ^ outCtrl_r.markerPolarityInvert;
    end
    frame_nxt = last_nxt ^ outCtrl_r.framePulseInvert;
  end

  // Serial output registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      selPrev_r <= 1'b0;
      pos_r     <= 13'h0000;
      blk_r     <= 7'h00;
      payload_r <= 1'b0;
      last_r    <= 1'b0;
      data_r    <= 1'b0;
      outClk_r  <= 1'b0;
      marker_r  <= 1'b0;
      frame_r   <= 1'b0;
    end else begin
      selPrev_r <= selClk;
      pos_r     <= pos_nxt;
      blk_r     <= blk_nxt;
      payload_r <= payload_nxt;
      last_r    <= last_nxt;
      data_r    <= data_nxt;
      outClk_r  <= outClk_nxt;
      marker_r  <= marker_nxt;
      frame_r   <= frame_nxt;
    end
  end

  // Alarm followers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      los_r <= 1'b0;
      oof_r <= 1'b0;
    end else begin
      los_r <= coreSignalLoss;
      oof_r <= coreOutOfFrame;
    end
  end

  // Update request and its rising edge
  assign updReq  = (updSync_r[2] & priCtrl_r.autoCounterUpdateEn) | priCtrl_r.manualCounterUpdate;
  assign updEdge = updReq & ~updPrev_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      updPrev_r  <= 1'b0;
      updPulse_r <= 1'b0;
    end else begin
      updPrev_r  <= updReq;
      updPulse_r <= updEdge;
    end
  end

  // Status view
  always_comb begin
    status            = 8'h00;
    status.signalLoss = los_r;
    status.outOfFrame = oof_r;
  end

  // Register next values and read mux
  always_comb begin
    outCtrl_nxt = outCtrl_r;
    priCtrl_nxt = priCtrl_r;
    errHeld_nxt = errHeld_r;
    rdata_nxt   = 8'h00;
    if (regWrite && regAddr == OUTPUT_CONTROL_OFS) begin
      outCtrl_nxt = regWdata;
    end
    if (regWrite && regAddr == PRIMARY_CONTROL_OFS) begin
      priCtrl_nxt = regWdata;
    end
    if (updEdge) begin
      errHeld_nxt = coreErrCount;
    end
    if (regRead) begin
      case (regAddr)
        OUTPUT_CONTROL_OFS:  rdata_nxt = outCtrl_r;
        PRIMARY_CONTROL_OFS: rdata_nxt = priCtrl_r;
        FRAMER_STATUS_OFS:   rdata_nxt = status;
        ERR_COUNT_LO_OFS:    rdata_nxt = errHeld_r[7:0];
        ERR_COUNT_HI_OFS:    rdata_nxt = errHeld_r[15:8];
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      outCtrl_r <= OUTPUT_CTRL_RST;
      priCtrl_r <= PRIMARY_CTRL_RST;
      errHeld_r <= 16'h0000;
      rdata_r   <= 8'h00;
    end else begin
      outCtrl_r <= outCtrl_nxt;
      priCtrl_r <= priCtrl_nxt;
      errHeld_r <= errHeld_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // Port drives
  assign rxOutputClock      = outClk_r;
  assign rxSerialDataOut    = data_r;
  assign rxPayloadEnable    = marker_r;
  assign rxFramePulse       = frame_r;
  assign rxSignalLossOut    = los_r;
  assign rxOutOfFrameOut    = oof_r;
  assign counterUpdatePulse = updPulse_r;
  assign regRdata           = rdata_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  localparam int DEADLINE = LOAD_DEADLINE_CYC;

  sequence s_updateEdge;
    updReq && !updPrev_r;
  endsequence
  sequence s_loaded;
    errHeld_r == $past(coreErrCount) && counterUpdatePulse;
  endsequence

  property p_enable_mode;
    !outCtrl_r.markerModeSelect |=> (rxPayloadEnable == (payload_r ^ $past(outCtrl_r.markerPolarityInvert)));
  endproperty
  a_enable_mode: assert property (p_enable_mode) else $error("data enable wrong");

  property p_gap_still;
    outCtrl_r.markerModeSelect && !payload_nxt |=> rxPayloadEnable == $past(outCtrl_r.markerPolarityInvert);
  endproperty
  a_gap_still: assert property (p_gap_still) else $error("gapped clock moved on overhead");

  property p_e3_overhead;
    tick && outCtrl_r.e3Mode && pos_nxt < E3_OVH_BITS |=> !payload_r;
  endproperty
  a_e3_overhead: assert property (p_e3_overhead) else $error("E3 overhead marked as payload");

  property p_ds3_overhead;
    tick && !outCtrl_r.e3Mode |=> payload_r == (blk_r != 7'h00);
  endproperty
  a_ds3_overhead: assert property (p_ds3_overhead) else $error("DS3 classification wrong");

  property p_frame_pulse;
    tick && isLastBit(outCtrl_r.e3Mode, pos_nxt) && !outCtrl_r.framePulseInvert |=> rxFramePulse;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse missing");

  property p_frame_pol;
    $stable(outCtrl_r) |=> rxFramePulse == (last_r ^ $past(outCtrl_r.framePulseInvert));
  endproperty
  a_frame_pol: assert property (p_frame_pol) else $error("frame pulse polarity wrong");

  property p_alarms;
    ##1 (rxSignalLossOut == $past(coreSignalLoss)) && (rxOutOfFrameOut == $past(coreOutOfFrame));
  endproperty
  a_alarms: assert property (p_alarms) else $error("alarm output lags state");

  property p_status;
    regRead && regAddr == FRAMER_STATUS_OFS |=> regRdata[1:0] == {$past(oof_r), $past(los_r)};
  endproperty
  a_status: assert property (p_status) else $error("status bits disagree");

  property p_load;
    s_updateEdge |-> ##[1:DEADLINE] s_loaded;
  endproperty
  a_load: assert property (p_load) else $error("counters not loaded in time");

  property p_single;
    counterUpdatePulse |=> !counterUpdatePulse;
  endproperty
  a_single: assert property (p_single) else $error("duplicate update");

  property p_gated;
    !priCtrl_r.autoCounterUpdateEn && !priCtrl_r.manualCounterUpdate |-> !updEdge;
  endproperty
  a_gated: assert property (p_gated) else $error("update while disabled");

  property p_data_hold;
    !tick |=> $stable(rxSerialDataOut);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data changed between source clock edges");

  property p_marker_hold;
    !tick && !outCtrl_r.markerModeSelect && $stable(outCtrl_r) |=> $stable(rxPayloadEnable);
  endproperty
  a_marker_hold: assert property (p_marker_hold) else $error("data enable moved between bits");

endmodule
`default_nettype wire

// File: verification/payload_sink.sv
// Downstream sink: samples the serial stream mid-bit and tallies each frame.
// Assumes all stream pins are registered on the system clock.
`default_nettype none
module payload_sink (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Stream from the port
  input  wire logic        rxOutputClock,
  input  wire logic        rxSerialDataOut,
  input  wire logic        rxPayloadEnable,
  input  wire logic        rxFramePulse,
  // Polarities in use
  input  wire logic        clkInv,
  input  wire logic        markerInv,
  input  wire logic        frameInv,
  // Tallies of the last whole frame
  output logic [7:0]       frameCount,
  output logic [15:0]      lastBits,
  output logic [15:0]      lastPay,
  output logic [15:0]      lastOnes,
  output logic [15:0]      lastGap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        ockPrev;
  logic        gapPrev;
  logic [15:0] bits;
  logic [15:0] pay;
  logic [15:0] ones;
  logic [15:0] gap;
  logic        mark;
  logic        sample;
  logic [15:0] gapN;
  // Sample on the edge opposite the launch edge
  assign mark = rxPayloadEnable ^ markerInv;
  assign sample = (ockPrev ^ clkInv) & ~(rxOutputClock ^ clkInv);
  assign gapN = gap + {15'h0, mark & ~gapPrev};
  // Count bits, payload, ones and gapped clock rises per frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {ockPrev, gapPrev, bits, pay, ones, gap, frameCount} <= '0;
      {lastBits, lastPay, lastOnes, lastGap} <= '0;
    end else begin
      ockPrev <= rxOutputClock;
      gapPrev <= mark;
      gap <= gapN;
      if (sample && (rxFramePulse ^ frameInv)) begin
        lastBits <= bits + 16'h1;
        lastPay <= pay + {15'h0, mark};
        lastOnes <= ones + {15'h0, rxSerialDataOut};
        lastGap <= gapN;
        frameCount <= frameCount + 8'h1;
        {bits, pay, ones, gap} <= '0;
      end else if (sample) begin
        bits <= bits + 16'h1;
        pay <= pay + {15'h0, mark};
        ones <= ones + {15'h0, rxSerialDataOut};
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the receive payload output port.
// Assumes 250 MHz clock and a 32 ns line clock made from it.
`default_nettype none
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin errTotal++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench
  import rx_payload_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, rxLineClock, txInputClock, coreBitData, coreFrameStart;
  logic coreSignalLoss, coreOutOfFrame, extCounterUpdateIn, counterUpdatePulse;
  logic rxOutputClock, rxSerialDataOut, rxPayloadEnable, rxFramePulse;
  logic rxSignalLossOut, rxOutOfFrameOut, regWrite, regRead;
  logic [15:0] coreErrCount, pos, frameLen, lastBits, lastPay, lastOnes, lastGap;
  logic [7:0]  regAddr, regWdata, regRdata, frameCount;
  logic [2:0]  linkPh;
  logic        streamOn, clkInv, markerInv, frameInv, ockPrev;
  int          errTotal, checksDone, updPulses, ockRises, cycles;

  receive_payload_output_port u_receive_payload_output_port (.clock(clock), .arst_n(arst_n),
    .rxLineClock(rxLineClock), .txInputClock(txInputClock), .coreBitData(coreBitData),
    .coreFrameStart(coreFrameStart), .coreSignalLoss(coreSignalLoss),
    .coreOutOfFrame(coreOutOfFrame), .coreErrCount(coreErrCount),
    .extCounterUpdateIn(extCounterUpdateIn), .counterUpdatePulse(counterUpdatePulse),
    .rxOutputClock(rxOutputClock), .rxSerialDataOut(rxSerialDataOut),
    .rxPayloadEnable(rxPayloadEnable), .rxFramePulse(rxFramePulse),
    .rxSignalLossOut(rxSignalLossOut), .rxOutOfFrameOut(rxOutOfFrameOut),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata));
  payload_sink u_payload_sink (.clock(clock), .arst_n(arst_n), .rxOutputClock(rxOutputClock),
    .rxSerialDataOut(rxSerialDataOut), .rxPayloadEnable(rxPayloadEnable),
    .rxFramePulse(rxFramePulse), .clkInv(clkInv), .markerInv(markerInv), .frameInv(frameInv),
    .frameCount(frameCount), .lastBits(lastBits), .lastPay(lastPay), .lastOnes(lastOnes),
    .lastGap(lastGap));

  // Clock source
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Line clock of 8 cycles; new bit on each fall, bit value is position parity
  always @(posedge clock) if (streamOn) begin
    linkPh <= linkPh + 3'h1;
    rxLineClock <= linkPh[2];
    if (linkPh == 3'h0) begin
      pos <= (pos >= frameLen - 16'h1) ? 16'h0 : pos + 16'h1;
      coreBitData <= (pos >= frameLen - 16'h1) ? 1'b0 : ~pos[0];
      coreFrameStart <= (pos >= frameLen - 16'h1);
    end
  end
  // Event tallies and run limit
  always @(posedge clock) begin
    cycles++;
    ockPrev <= rxOutputClock;
    if (counterUpdatePulse === 1'b1) updPulses++;
    if (rxOutputClock === 1'b1 && ockPrev === 1'b0) ockRises++;
    if (cycles == 100000) begin
      errTotal++;
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clock) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) {regRead, regAddr} <= {1'b1, a};
    @(posedge clock) regRead <= 1'b0;
    @(posedge clock) `CHK(regRdata, e)
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", errTotal, checksDone);
    if (errTotal == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Reset values, unmapped and read-only places
  task automatic t_reset();
    cyc(2);
    `CHK({rxOutputClock, rxPayloadEnable, rxFramePulse, rxSignalLossOut, rxOutOfFrameOut}, 5'h0)
    rd(OUTPUT_CONTROL_OFS, 8'h00);
    rd(8'h55, 8'h00);
    wr(FRAMER_STATUS_OFS, 8'hff);
    rd(FRAMER_STATUS_OFS, 8'h00);
    wr(OUTPUT_CONTROL_OFS, 8'h26);
    rd(OUTPUT_CONTROL_OFS, 8'h26);
  endtask
  // Alarm pins and status bits follow the framer states
  task automatic t_alarms();
    coreSignalLoss <= 1'b1;
    cyc(3);
    `CHK({rxSignalLossOut, rxOutOfFrameOut}, 2'b10)
    rd(FRAMER_STATUS_OFS, 8'h01);
    {coreSignalLoss, coreOutOfFrame} <= 2'b01;
    cyc(3);
    `CHK({rxSignalLossOut, rxOutOfFrameOut}, 2'b01)
    rd(FRAMER_STATUS_OFS, 8'h02);
    coreOutOfFrame <= 1'b0;
    cyc(3);
    `CHK({rxSignalLossOut, rxOutOfFrameOut}, 2'b00)
  endtask
  // External strobe gated by auto enable, one update per rise, manual OR
  task automatic t_counters();
    coreErrCount <= 16'h1234;
    extCounterUpdateIn <= 1'b1;
    cyc(25);
    extCounterUpdateIn <= 1'b0;
    `CHK(updPulses, 0)
    rd(ERR_COUNT_LO_OFS, 8'h00);
    wr(PRIMARY_CONTROL_OFS, 8'h08);
    extCounterUpdateIn <= 1'b1;
    cyc(25);
    `CHK(updPulses, 1)
    rd(ERR_COUNT_LO_OFS, 8'h34);
    rd(ERR_COUNT_HI_OFS, 8'h12);
    coreErrCount <= 16'h5678;
    cyc(25);
    `CHK(updPulses, 1)
    extCounterUpdateIn <= 1'b0;
    cyc(8);
    extCounterUpdateIn <= 1'b1;
    cyc(25);
    `CHK(updPulses, 2)
    rd(ERR_COUNT_HI_OFS, 8'h56);
    extCounterUpdateIn <= 1'b0;
    wr(PRIMARY_CONTROL_OFS, 8'h00);
    coreErrCount <= 16'h9abc;
    wr(PRIMARY_CONTROL_OFS, 8'h10);
    cyc(25);
    `CHK(updPulses, 3)
    rd(ERR_COUNT_LO_OFS, 8'hbc);
    wr(PRIMARY_CONTROL_OFS, 8'h00);
  endtask
  // Stream frames under one setup and judge the last whole frame
  task automatic t_frames(input logic [7:0] cfg, input logic [15:0] len, input logic [15:0] expPay,
                          input logic [7:0] n);
    logic [7:0] tgt;
    int         k;
    wr(OUTPUT_CONTROL_OFS, cfg);
    cyc(1);
    {clkInv, frameInv, markerInv} <= {cfg[3], cfg[2], cfg[1]}; // Switch with the port's outputs
    frameLen <= len;
    streamOn <= 1'b1;
    tgt = frameCount + n;
    k = 0;
    while (frameCount !== tgt && k < 60000) begin
      @(posedge clock);
      k++;
    end
    `CHK(frameCount, tgt)
    `CHK(lastBits, len)
    `CHK(lastOnes, len >> 1)
    `CHK(cfg[0] ? lastGap : lastPay, expPay)
  endtask
  // Output clock follows the transmit clock in loopback
  task automatic t_loopback();
    int r0;
    wr(OUTPUT_CONTROL_OFS, 8'h10);
    cyc(8);
    r0 = ockRises;
    cyc(40);
    `CHK(ockRises - r0, 0)
    repeat (10) begin
      cyc(4);
      txInputClock <= ~txInputClock;
    end
    cyc(8);
    `CHK(ockRises - r0, 5)
    wr(OUTPUT_CONTROL_OFS, 8'h00);
    cyc(8);
    r0 = ockRises;
    cyc(40);
    `CHK(ockRises - r0, 5)
  endtask

  // Main sequence
  initial begin
    {arst_n, rxLineClock, txInputClock, coreBitData, coreFrameStart, coreSignalLoss} = '0;
    {coreOutOfFrame, extCounterUpdateIn, regWrite, regRead, streamOn, ockPrev} = '0;
    {clkInv, markerInv, frameInv, linkPh, regAddr, regWdata} = '0;
    {coreErrCount, pos, frameLen} = {16'h0, 16'hffff, 16'd4760};
    {errTotal, checksDone, updPulses, ockRises, cycles} = '0;
    cyc(20);
    arst_n <= 1'b1;
    t_reset();
    wr(OUTPUT_CONTROL_OFS, 8'h00);
    t_alarms();
    t_counters();
    t_frames(8'h00, 16'd4760, 16'd4704, 8'd1);
    t_loopback();
    t_frames(8'h2e, 16'd1536, 16'd1524, 8'd2);
    t_frames(8'h23, 16'd1536, 16'd1524, 8'd2);
    print_verdict();
  end
endmodule
`default_nettype wire
